// ---- common/phy_ext_page1_defines.svh ----
// register map, field positions and reset values of the extended page one bank
`ifndef PHY_EXT_PAGE1_DEFINES_SVH
`define PHY_EXT_PAGE1_DEFINES_SVH
// register indices, byte address is four times the index
`define IDX_SLEEP_DS 6'h14
`define IDX_POE_CRC 6'h17
`define IDX_DIAG_ONE 6'h18
`define IDX_PAGE 6'h1F
`define IDX_IRQ_STAT 6'h20
`define IDX_IRQ_MASK 6'h21
`define IDX_SOFT_CTRL 6'h22
`define PAGE_MAIN 16'h0000
`define PAGE_EXT1 16'h0001
// sleep and downshift register fields
`define SD_REV 9
`define SD_MEDIA_HI 7
`define SD_MEDIA_LO 6
`define SD_NOPRE 5
`define SD_DSEN 4
`define SD_DSCNT_HI 3
`define SD_DSCNT_LO 2
`define SD_DSSTAT 1
`define DSCNT_RST 2'h1
`define DS_BASE 3'h2
`define MEDIA_NONE 2'h0
`define MEDIA_COPPER 2'h1
// inline power and crc register fields
`define PC_ADDR_HI 15
`define PC_ADDR_LO 11
`define PC_PDEN 10
`define PC_PDST_HI 9
`define PC_PDST_LO 8
`define PC_CRC_HI 7
`define PC_CRC_LO 0
`define PD_SEARCHING 2'h0
`define CRC_MAX 8'hFF
`define CRC_ONE 8'h01
`define CRC_ZERO 8'h00
// cable diagnostic register fields
`define DG_TRIG 15
`define DG_VALID 14
`define DG_A_HI 13
`define DG_A_LO 8
`define DG_B_HI 5
`define DG_B_LO 0
`define DIST_ZERO 6'h00
`define METRES_PER_COUNT 3
// interrupt and soft reset fields
`define IRQ_DIAG 0
`define IRQ_CRCSAT 1
`define IRQ_DSHIFT 2
`define IRQ_NUM 3
`define SOFT_RST_BIT 0
`define PORT_MAX 2'h3
`endif

// ---- common/phy_ext_page1_pkg.sv ----
// types shared by the extended page one register bank
`default_nettype none
package phy_ext_page1_pkg;
    typedef enum logic {DIAG_IDLE, DIAG_RUN} diag_state_e;
    typedef struct packed {
        logic [5:0] distA;
        logic [5:0] distB;
    } diag_result_s;
    typedef struct packed {
        logic [1:0] portIdx;
        logic [4:0] phyAddr;
    } strap_s;
endpackage
`default_nettype wire

// ---- logic/phy_ext_page1_ctrl_diag_regs.sv ----
// extended page one control, status and cable diagnostic register bank
//
// Register access over APB was left to the implementer.
`default_nettype none
`include "phy_ext_page1_defines.svh"
// Operation
// [R1] reversal bit set maps ports zero..three to addresses three..zero
// [R2] host sets reversal via port zero first, clears via port three first
// [R3] media status reads 00 with no media, 01 with copper
// [R4] no-preamble bit lets 10BASE-T raise receive valid without preamble
// [R5] sticky enable turns on automatic downshift from gigabit, default off
// [R6] downshift code 00..11 means two..five failed attempts, default 01
// [R7] downshift status reads one once downshift needed or done, resets zero
// [R8] address field returns port address latched at reset, not writable
// [R9] detection status meaningful only while sticky detection enable is set
// [R10] detection codes: 00 searching, 01 needs power, 10 no power
// [R11] crc error counter saturates at FF and clears when read
// [R12] writing one starts diagnostic; bit stays set until it finishes
// [R13] results valid after trigger clears; valid bit then reads one
// [R14] pair A distance in 13:8, pair B in 5:0, reset zero
// [R15] one distance count stands for three metres of cable
// [R16] writing zero to page select returns to main register set
// [R17] sticky fields survive soft reset, reset only on hardware reset
// [R18] writes to read-only bits ignored, reserved bits read zero
module phy_ext_page1_ctrl_diag_regs
    import phy_ext_page1_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // strap pins
    input wire logic [1:0] portIdxPin,
    input wire logic [4:0] phyAddrPin,
    // port core status
    input wire logic copperSel,
    input wire logic downshiftEvent,
    input wire logic crcErr,
    input wire logic [1:0] pdStatus,
    // diagnostic engine
    input wire logic diagDone,
    input wire diag_result_s diagResult,
    output logic diagStart,
    // port core controls and interrupt
    output logic [4:0] mgmtAddr,
    output logic noPreambleEn,
    output logic downshiftEn,
    output logic [2:0] downshiftAttempts,
    output logic pdDetectEn,
    output logic irq
);
    strap_s pinMeta_r, pinSync_r, strap_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [15:0] page_r;
    logic revEn_r, noPre_r, dsEn_r, dsStat_r, pdEn_r;
    logic [1:0] dsCnt_r;
    logic [7:0] crcCnt_r;
    diag_state_e diagState_r;
    logic diagValid_r, diagStart_r;
    diag_result_s diagRes_r;
    logic [`IRQ_NUM-1:0] irqStat_r, irqMask_r, irqEvt;
    logic [4:0] mgmtAddr_r;
    logic noPreOut_r, dsEnOut_r, pdEnOut_r;
    logic [2:0] dsAtt_r;
    logic setup, access, wrAcc, rdSetup, extPage, softRst;
    logic [15:0] wd, rdSleep, rdPoe, rdDiag;
    logic [5:0] idx;

    // register hit for the current address; page gating of extended ones is left to the callers
    function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
        hit = (a == r);
    endfunction

    assign idx = paddr[7:2];
    assign wd = pwdata[15:0];
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wrAcc = access && pwrite;
    assign rdSetup = setup && !pwrite;
    assign extPage = (page_r == `PAGE_EXT1);
    assign softRst = wrAcc && hit(idx, `IDX_SOFT_CTRL) && wd[`SOFT_RST_BIT];
    assign pready = access;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;

    // strap synchroniser and capture while reset is held
    always_ff @(posedge core_clk) begin
        pinMeta_r <= '{portIdx: portIdxPin, phyAddr: phyAddrPin};
        pinSync_r <= pinMeta_r;
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            strap_r <= pinSync_r; // R8
        end
    end

    // read views, reserved and unused bits zero
    always_comb begin
        rdSleep = 16'h0000; // R18
        rdSleep[`SD_REV] = revEn_r;
        rdSleep[`SD_MEDIA_HI:`SD_MEDIA_LO] = copperSel ? `MEDIA_COPPER : `MEDIA_NONE; // R3
        rdSleep[`SD_NOPRE] = noPre_r;
        rdSleep[`SD_DSEN] = dsEn_r;
        rdSleep[`SD_DSCNT_HI:`SD_DSCNT_LO] = dsCnt_r;
        rdSleep[`SD_DSSTAT] = dsStat_r; // R7
        rdPoe = 16'h0000;
        rdPoe[`PC_ADDR_HI:`PC_ADDR_LO] = mgmtAddr_r; // R8
        rdPoe[`PC_PDEN] = pdEn_r;
        rdPoe[`PC_PDST_HI:`PC_PDST_LO] = pdEn_r ? pdStatus : `PD_SEARCHING; // R9 R10
        rdPoe[`PC_CRC_HI:`PC_CRC_LO] = crcCnt_r;
        rdDiag = 16'h0000;
        rdDiag[`DG_TRIG] = (diagState_r == DIAG_RUN);
        rdDiag[`DG_VALID] = diagValid_r; // R13
        rdDiag[`DG_A_HI:`DG_A_LO] = diagRes_r.distA; // R14
        rdDiag[`DG_B_HI:`DG_B_LO] = diagRes_r.distB; // R14
    end

    // apb read data and error, captured in the setup cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            if (!pwrite) begin
                case (idx)
                    `IDX_SLEEP_DS: prdata_r[15:0] <= extPage ? rdSleep : 16'h0000;
                    `IDX_POE_CRC: prdata_r[15:0] <= extPage ? rdPoe : 16'h0000;
                    `IDX_DIAG_ONE: prdata_r[15:0] <= extPage ? rdDiag : 16'h0000;
                    `IDX_PAGE: prdata_r[15:0] <= page_r;
                    `IDX_IRQ_STAT: prdata_r[`IRQ_NUM-1:0] <= irqStat_r;
                    `IDX_IRQ_MASK: prdata_r[`IRQ_NUM-1:0] <= irqMask_r;
                    `IDX_SOFT_CTRL: prdata_r <= 32'h0000_0000;
                    default: pslverr_r <= 1'b1;
                endcase
            end else begin
                case (idx)
                    `IDX_SLEEP_DS, `IDX_POE_CRC, `IDX_DIAG_ONE, `IDX_PAGE,
                    `IDX_IRQ_STAT, `IDX_IRQ_MASK, `IDX_SOFT_CTRL: pslverr_r <= 1'b0;
                    default: pslverr_r <= 1'b1;
                endcase
            end
        end
    end

    // page select
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            page_r <= `PAGE_MAIN;
        end else if (wrAcc && hit(idx, `IDX_PAGE)) begin
            page_r <= wd; // R16
        end
    end

    // sticky controls, hardware reset only
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            noPre_r <= 1'b0;
            dsEn_r <= 1'b0; // R5
            dsCnt_r <= `DSCNT_RST; // R6
            pdEn_r <= 1'b0;
        end else if (wrAcc && extPage) begin // R17
            if (hit(idx, `IDX_SLEEP_DS)) begin
                noPre_r <= wd[`SD_NOPRE]; // R4
                dsEn_r <= wd[`SD_DSEN]; // R5
                dsCnt_r <= wd[`SD_DSCNT_HI:`SD_DSCNT_LO]; // R6
            end
            if (hit(idx, `IDX_POE_CRC)) begin
                pdEn_r <= wd[`PC_PDEN]; // R9
            end
        end
    end

    // address reversal, cleared by either reset
    always_ff @(posedge core_clk) begin
        if (sys_rst || softRst) begin
            revEn_r <= 1'b0;
        end else if (wrAcc && extPage && hit(idx, `IDX_SLEEP_DS)) begin
            revEn_r <= wd[`SD_REV]; // R1
        end
    end

    // downshift status, set wins over soft reset
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dsStat_r <= 1'b0; // R7
        end else if (downshiftEvent) begin
            dsStat_r <= 1'b1; // R7
        end else if (softRst) begin
            dsStat_r <= 1'b0;
        end
    end

    // saturating crc error counter, read clears in setup cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            crcCnt_r <= `CRC_ZERO;
        end else if ((rdSetup && extPage && hit(idx, `IDX_POE_CRC)) || softRst) begin
            crcCnt_r <= crcErr ? `CRC_ONE : `CRC_ZERO; // R11
        end else if (crcErr && crcCnt_r != `CRC_MAX) begin
            crcCnt_r <= crcCnt_r + `CRC_ONE; // R11
        end
    end

    // cable diagnostic sequencing
    always_ff @(posedge core_clk) begin
        if (sys_rst || softRst) begin
            diagState_r <= DIAG_IDLE;
            diagValid_r <= 1'b0;
            diagStart_r <= 1'b0;
            diagRes_r <= '{distA: `DIST_ZERO, distB: `DIST_ZERO}; // R14
        end else begin
            diagStart_r <= 1'b0;
            case (diagState_r)
                DIAG_IDLE: begin
                    if (wrAcc && extPage && hit(idx, `IDX_DIAG_ONE) && wd[`DG_TRIG]) begin
                        diagState_r <= DIAG_RUN; // R12
                        diagValid_r <= 1'b0;
                        diagStart_r <= 1'b1;
                    end
                end
                DIAG_RUN: begin
                    if (diagDone) begin
                        diagState_r <= DIAG_IDLE; // R12
                        diagValid_r <= 1'b1; // R13
                        diagRes_r <= diagResult; // R15
                    end
                end
                default: diagState_r <= DIAG_IDLE;
            endcase
        end
    end

    // interrupt events, set wins over write-one-to-clear
    assign irqEvt[`IRQ_DIAG] = diagDone && (diagState_r == DIAG_RUN);
    assign irqEvt[`IRQ_CRCSAT] = crcErr && (crcCnt_r == `CRC_MAX);
    assign irqEvt[`IRQ_DSHIFT] = downshiftEvent;
    for (genvar i = 0; i < `IRQ_NUM; i++) begin : g_irq
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                irqStat_r[i] <= 1'b0;
            end else if (irqEvt[i]) begin
                irqStat_r[i] <= 1'b1;
            end else if (wrAcc && hit(idx, `IDX_IRQ_STAT) && wd[i]) begin
                irqStat_r[i] <= 1'b0;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irqMask_r <= '0;
        end else if (wrAcc && hit(idx, `IDX_IRQ_MASK)) begin
            irqMask_r <= wd[`IRQ_NUM-1:0];
        end
    end
    assign irq = |(irqStat_r & irqMask_r);

    // registered controls towards the port core
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mgmtAddr_r <= 5'h00;
            noPreOut_r <= 1'b0;
            dsEnOut_r <= 1'b0;
            dsAtt_r <= 3'h0;
            pdEnOut_r <= 1'b0;
        end else begin
            mgmtAddr_r <= {strap_r.phyAddr[4:2], revEn_r ? (`PORT_MAX - strap_r.portIdx) : strap_r.portIdx}; // R1
            noPreOut_r <= noPre_r; // R4
            dsEnOut_r <= dsEn_r;
            dsAtt_r <= `DS_BASE + {1'b0, dsCnt_r}; // R6
            pdEnOut_r <= pdEn_r;
        end
    end
    assign mgmtAddr = mgmtAddr_r;
    assign noPreambleEn = noPreOut_r;
    assign downshiftEn = dsEnOut_r;
    assign downshiftAttempts = dsAtt_r;
    assign pdDetectEn = pdEnOut_r;
    assign diagStart = diagStart_r;

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_wrExt(logic [5:0] r);
        wrAcc && extPage && idx == r;
    endsequence
    sequence s_diagRun;
        diagState_r == DIAG_RUN && !diagDone && !softRst;
    endsequence

    property p_addrMap;
        1 |=> mgmtAddr[1:0] == ($past(revEn_r) ? ~$past(strap_r.portIdx) : $past(strap_r.portIdx));
    endproperty
    a_addrMap: assert property (p_addrMap) else $error("address mapping wrong"); // R1
    property p_media;
        rdSetup && extPage && idx == `IDX_SLEEP_DS |=>
            prdata[`SD_MEDIA_HI:`SD_MEDIA_LO] == ($past(copperSel) ? `MEDIA_COPPER : `MEDIA_NONE);
    endproperty
    a_media: assert property (p_media) else $error("media status wrong"); // R3
    property p_noPre;
        s_wrExt(`IDX_SLEEP_DS) |=> ##1 noPreambleEn == $past(wd[`SD_NOPRE], 2);
    endproperty
    a_noPre: assert property (p_noPre) else $error("no preamble control lost"); // R4
    property p_dsAtt;
        s_wrExt(`IDX_SLEEP_DS) |=> ##1 downshiftAttempts == `DS_BASE + 3'($past(wd[`SD_DSCNT_HI:`SD_DSCNT_LO], 2));
    endproperty
    a_dsAtt: assert property (p_dsAtt) else $error("downshift count wrong"); // R6
    property p_dsStat;
        downshiftEvent |=> dsStat_r;
    endproperty
    a_dsStat: assert property (p_dsStat) else $error("downshift status not set"); // R7
    property p_crcSat;
        crcCnt_r == `CRC_MAX && !rdSetup && !softRst |=> crcCnt_r == `CRC_MAX;
    endproperty
    a_crcSat: assert property (p_crcSat) else $error("crc counter wrapped"); // R11
    property p_crcClr;
        rdSetup && extPage && idx == `IDX_POE_CRC && !crcErr |=> crcCnt_r == `CRC_ZERO;
    endproperty
    a_crcClr: assert property (p_crcClr) else $error("crc counter not cleared"); // R11
    property p_diagStart;
        s_wrExt(`IDX_DIAG_ONE) ##0 (wd[`DG_TRIG] && diagState_r == DIAG_IDLE) |=>
            diagStart && !diagValid_r ##1 !diagStart;
    endproperty
    a_diagStart: assert property (p_diagStart) else $error("diagnostic start wrong"); // R12
    property p_diagHold;
        s_diagRun |=> diagState_r == DIAG_RUN && !diagValid_r;
    endproperty
    a_diagHold: assert property (p_diagHold) else $error("trigger dropped early"); // R12
    property p_diagEnd;
        diagState_r == DIAG_RUN && diagDone && !softRst |=> diagState_r == DIAG_IDLE && diagValid_r;
    endproperty
    a_diagEnd: assert property (p_diagEnd) else $error("diagnostic end wrong"); // R13
    property p_sticky;
        softRst |=> dsEn_r == $past(dsEn_r) && dsCnt_r == $past(dsCnt_r) && pdEn_r == $past(pdEn_r);
    endproperty
    a_sticky: assert property (p_sticky) else $error("sticky field lost on soft reset"); // R17
    property p_page;
        wrAcc && idx == `IDX_PAGE && wd == `PAGE_MAIN |=> !extPage;
    endproperty
    a_page: assert property (p_page) else $error("page not returned to main"); // R16
    property p_pdGate;
        rdSetup && extPage && idx == `IDX_POE_CRC && !pdEn_r |=> prdata[`PC_PDST_HI:`PC_PDST_LO] == `PD_SEARCHING;
    endproperty
    a_pdGate: assert property (p_pdGate) else $error("detection status shown while disabled"); // R9
    property p_addrRo;
        rdSetup && extPage && idx == `IDX_POE_CRC |=> prdata[`PC_ADDR_HI:`PC_ADDR_LO] == $past(mgmtAddr);
    endproperty
    a_addrRo: assert property (p_addrRo) else $error("address field wrong"); // R8
    property p_irqSet;
        |irqEvt |=> (irqStat_r & $past(irqEvt)) == $past(irqEvt);
    endproperty
    a_irqSet: assert property (p_irqSet) else $error("interrupt event lost");
    property p_diagValid;
        diagValid_r |-> diagState_r == DIAG_IDLE;
    endproperty
    a_diagValid: assert property (p_diagValid) else $error("results valid while running"); // R13
    property p_revSoft;
        softRst |=> !revEn_r;
    endproperty
    a_revSoft: assert property (p_revSoft) else $error("reversal kept over soft reset"); // R17
    property p_crcInc;
        crcErr && crcCnt_r != `CRC_MAX && !rdSetup && !softRst |=> crcCnt_r == $past(crcCnt_r) + `CRC_ONE;
    endproperty
    a_crcInc: assert property (p_crcInc) else $error("crc counter missed an error"); // R11
endmodule
`default_nettype wire

// ---- verification/diag_engine_model.sv ----
// behavioural cable diagnostic engine answering start pulses
`default_nettype none
module diag_engine_model
    import phy_ext_page1_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // control from the bank and the bench
    input wire logic diagStart,
    input wire logic [7:0] runCycles,
    input wire diag_result_s result,
    // answer to the bank
    output logic diagDone,
    output diag_result_s diagResult
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;
    logic busy_r;
    logic [11:0] junk_r;
    always_ff @(posedge core_clk) begin
        diagDone <= 1'b0;
        if (sys_rst) begin
            busy_r <= 1'b0;
            cnt_r <= 8'h00;
        end else if (diagStart) begin
            busy_r <= 1'b1;
            cnt_r <= runCycles;
        end else if (busy_r && cnt_r == 8'h00) begin
            busy_r <= 1'b0;
            diagDone <= 1'b1;
        end else if (busy_r) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end
    // results hold only with the done pulse
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            junk_r <= 12'h000;
        end else begin
            junk_r <= junk_r + 12'h001;
        end
    end
    assign diagResult = diagDone ? result : diag_result_s'(~junk_r);
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the extended page one register bank
`default_nettype none
`include "phy_ext_page1_defines.svh"
module testbench
    import phy_ext_page1_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_SD = {`IDX_SLEEP_DS, 2'b00};
    localparam logic [7:0] A_PC = {`IDX_POE_CRC, 2'b00};
    localparam logic [7:0] A_DG = {`IDX_DIAG_ONE, 2'b00};
    localparam logic [7:0] A_PG = {`IDX_PAGE, 2'b00};
    localparam logic [7:0] A_IS = {`IDX_IRQ_STAT, 2'b00};
    localparam logic [7:0] A_IM = {`IDX_IRQ_MASK, 2'b00};
    localparam logic [7:0] A_SR = {`IDX_SOFT_CTRL, 2'b00};
    localparam logic [7:0] A_BAD = 8'h04;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] portIdxPin = 2'h0;
    logic [4:0] phyAddrPin = 5'h14;
    logic copperSel = 1'b0;
    logic downshiftEvent = 1'b0;
    logic crcErr = 1'b0;
    logic [1:0] pdStatus = 2'h0;
    logic diagDone;
    diag_result_s diagResult;
    diag_result_s result = '{6'h00, 6'h00};
    logic [7:0] runCycles = 8'h0A;
    logic diagStart;
    logic [4:0] mgmtAddr;
    logic noPreambleEn;
    logic downshiftEn;
    logic [2:0] downshiftAttempts;
    logic pdDetectEn;
    logic irq;
    int n_errors = 0;
    int n_compared = 0;
    logic [31:0] rdat;
    logic rerr;

    always #12.5 core_clk = ~core_clk;

    phy_ext_page1_ctrl_diag_regs phy_ext_page1_ctrl_diag_regs_i (
        .core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .portIdxPin, .phyAddrPin, .copperSel, .downshiftEvent,
        .crcErr, .pdStatus, .diagDone, .diagResult, .diagStart, .mgmtAddr,
        .noPreambleEn, .downshiftEn, .downshiftAttempts, .pdDetectEn, .irq
    );
    diag_engine_model diag_engine_model_i (
        .core_clk, .sys_rst, .diagStart, .runCycles, .result, .diagDone, .diagResult
    );

    task final_report;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer, outputs other than the registered port core controls settled on return
    task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge core_clk);
    endtask

    task wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a, input logic [15:0] exp);
        apb(1'b0, a, 16'h0000);
        chk(rdat[15:0], exp, "read data");
        chk(rdat[31:16], 16'h0000, "upper half");
        chk(16'(rerr), 16'(a == A_BAD), "slave error");
    endtask

    task crc(input int n);
        repeat (n) begin
            @(posedge core_clk);
            crcErr <= 1'b1;
            @(posedge core_clk);
            crcErr <= 1'b0;
        end
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(A_SD, 16'h0000);
        wr(A_PG, 16'h0001);
        rd(A_SD, 16'h0004);
        rd(A_DG, 16'h0000);
        chk(16'(downshiftAttempts), 16'h0003, "attempts");
        chk(16'(downshiftEn), 16'h0000, "downshift enable");
        @(posedge core_clk);
        copperSel <= 1'b1;
        rd(A_SD, 16'h0044);
        $display("test defaults done");
        // reversal is set from port zero
        wr(A_SD, 16'hFFFF);
        rd(A_SD, 16'h027C);
        chk(16'(mgmtAddr), 16'h0017, "reversed address");
        chk(16'({noPreambleEn, downshiftEn}), 16'h0003, "enables");
        rd(A_PC, 16'hB800);
        for (int c = 0; c < 4; c++) begin
            wr(A_SD, 16'(c << 2));
            rd(A_SD, 16'(c << 2) | 16'h0040);
            chk(16'(downshiftAttempts), 16'(c + 2), "attempts");
        end
        chk(16'(mgmtAddr), 16'h0014, "plain address");
        $display("test control fields done");
        @(posedge core_clk);
        downshiftEvent <= 1'b1;
        @(posedge core_clk);
        downshiftEvent <= 1'b0;
        rd(A_SD, 16'h004E);
        rd(A_IS, 16'h0004);
        wr(A_IS, 16'h0004);
        rd(A_IS, 16'h0000);
        $display("test downshift done");
        crc(3);
        rd(A_PC, 16'hA003);
        rd(A_PC, 16'hA000);
        crc(300);
        rd(A_PC, 16'hA0FF);
        rd(A_PC, 16'hA000);
        rd(A_IS, 16'h0002);
        wr(A_IS, 16'h0002);
        $display("test crc counter done");
        @(posedge core_clk);
        pdStatus <= 2'h1;
        rd(A_PC, 16'hA000);
        wr(A_PC, 16'hFFFF);
        for (int c = 0; c < 3; c++) begin
            @(posedge core_clk);
            pdStatus <= 2'(c);
            rd(A_PC, 16'hA400 | 16'(c << 8));
        end
        chk(16'(pdDetectEn), 16'h0001, "detect enable");
        $display("test detection done");
        @(posedge core_clk);
        result <= '{6'h2A, 6'h15};
        wr(A_IM, 16'h0001);
        wr(A_DG, 16'h8000);
        rd(A_DG, 16'h8000);
        chk(16'(irq), 16'h0000, "irq early");
        for (int k = 0; k < 20 && rdat[15]; k++) begin
            apb(1'b0, A_DG, 16'h0000);
        end
        rd(A_DG, 16'h6A15);
        chk(16'(irq), 16'h0001, "irq raised");
        wr(A_IM, 16'h0000);
        chk(16'(irq), 16'h0000, "irq masked");
        wr(A_IM, 16'h0001);
        wr(A_IS, 16'h0001);
        chk(16'(irq), 16'h0000, "irq cleared");
        $display("test diagnostic done");
        wr(A_SD, 16'h0238);
        wr(A_SR, 16'h0001);
        rd(A_SD, 16'h0078);
        rd(A_DG, 16'h0000);
        rd(A_PC, 16'hA600);
        rd(A_PG, 16'h0001);
        rd(A_BAD, 16'h0000);
        wr(A_PG, 16'h0000);
        rd(A_PC, 16'h0000);
        $display("test soft reset and paging done");
        final_report;
    end

    initial begin
        repeat (8000) @(posedge core_clk);
        n_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        final_report;
    end
endmodule
`default_nettype wire
